// *** plst_pkg.sv ***
// Purpose: shared constants for the pll status and loop tuning block
// Assumes: single 20 MHz clock domain
// Notes:   field positions of the loop tuning bits and mode codes
package plst_pkg;
   // ==========================================================
   // mode codes
   typedef enum logic [1:0] {
      PLST_MODE_LOW_BW  = 2'h0,
      PLST_MODE_SYNTH   = 2'h1,
      PLST_MODE_HIGH_BW = 2'h2,
      PLST_MODE_HIGH_B2 = 2'h3
   } plst_mode_t;

   // ==========================================================
   // tuning field layout
   localparam int          TUNE_W          = 7;
   localparam logic [6:0]  TUNE_RESET      = 7'h00;
   localparam int          LF_HI           = 6;
   localparam int          LF_LO           = 5;
   localparam int          ORD_BIT         = 4;
   localparam int          MODULATOR_ENABLE_BIT_BIT      = 3;
   localparam int          GAIN_HI         = 6;
   localparam int          GAIN_LO         = 3;
   localparam int          CP_HI           = 2;
   localparam int          CP_LO           = 1;
   localparam int          REDUCE_BIT      = 0;
   localparam logic [1:0]  FORCED_CODE     = 2'h0;
   localparam logic [1:0]  CP_RESERVED     = 2'h3;

   // ==========================================================
   // pump currents in microamps
   localparam logic [9:0]  UPPER_UA_0      = 10'h0AD;  // 173
   localparam logic [9:0]  UPPER_UA_1      = 10'h15A;  // 346
   localparam logic [9:0]  UPPER_UA_2      = 10'h2B4;  // 692
   localparam logic [9:0]  LOWER_UA_0      = 10'h320;  // 800
   localparam logic [9:0]  LOWER_UA_1      = 10'h190;  // 400
   localparam logic [9:0]  LOWER_UA_2      = 10'h0C8;  // 200
   localparam logic [9:0]  LOWER_UA_3      = 10'h064;  // 100

   // ==========================================================
   // status word bit positions
   localparam int          ST_IN0          = 0;
   localparam int          ST_IN1          = 1;
   localparam int          ST_XTAL         = 2;
   localparam int          ST_LOCK         = 3;
   localparam int          ST_FREEZE       = 4;
   localparam int          ST_ACTIVE       = 5;
   localparam int          ST_W            = 6;
endpackage

// *** plst_top.sv ***
// Purpose: status flags with pin mirrors and mode-dependent loop tuning decode
// Assumes: condition inputs synchronous to clk; tuning field written through wr_en
// Notes:   status word is read only; writes only reach the tuning field
`timescale 1ns/1ps

// Behaviour
// RL1 - input 0 fail flag is 1 while bad, self clears, mirrored on pin
// RL2 - input 1 fail flag is 1 while bad, self clears, mirrored on pin
// RL3 - crystal fail flag is 1 while bad, self clears, mirrored on pin
// RL4 - lock flag is 1 while locked, mirrored on lock pin
// RL5 - freeze flag set when detector input bad, oscillator held, pin mirror
// RL6 - active input shown in status bit and pin, follows fail-over
// RL7 - synth and high-bw modes split field into filter, order, enable, pump, reduce
// RL8 - low-bw mode splits field into gain, lower pump, reduce
// RL9 - low-bw mode forces upper filter code to 00
// RL10 - order bit 0 gives second order, 1 gives third order
// RL11 - enable bit 0 integer feedback, 1 fractional through modulator
// RL12 - upper pump 173/346/692 uA, 11 reserved, 00 forced in low-bw
// RL13 - reduce bit lowers upper pump current by one third
// RL14 - lower pump 800/400/200/100 uA, used only in low-bw
// RL15 - software picks pump 10, no reduce, filter 11 for 4 MHz
// RL16 - mode code 00 low-bw, 01 synth, 10 or 11 high-bw
// RL17 - status flags read only and follow conditions within few cycles
module plst_top (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [1:0]  mode_sel,
   input  wire logic        wr_en,
   input  wire logic [6:0]  wr_data,
   input  wire logic        in0_bad,
   input  wire logic        in1_bad,
   input  wire logic        xtal_bad,
   input  wire logic        locked,
   input  wire logic        detector_bad,
   input  wire logic        active_input,
   output logic [6:0]       loop_tuning_bits,
   output logic [5:0]       status_word,
   output logic             input0_fail_flag,
   output logic             input1_fail_flag,
   output logic             crystal_fail_flag,
   output logic             pll_lock_flag,
   output logic             freeze_state_flag,
   output logic             active_input_flag,
   output logic             oscillator_hold,
   output logic [1:0]       upper_loop_filter_sel,
   output logic             modulator_order_bit,
   output logic             modulator_enable_bit,
   output logic [1:0]       upper_pump_current_sel,
   output logic             upper_pump_reduce_bit,
   output logic [3:0]       converter_gain,
   output logic [1:0]       lower_pump_current_sel,
   output logic [9:0]       upper_pump_ua,
   output logic [9:0]       lower_pump_ua,
   output logic             third_order,
   output logic             fractional_feedback,
   output logic             lower_loop_on,
   output logic             upper_cp_reserved
);

   // ==========================================================
   // status capture
   logic [5:0] next_status;
   logic [6:0] next_tune;

   // each flag just follows its condition; no write path exists into status
   always_comb begin
      next_status                     = '0;
      next_status[plst_pkg::ST_IN0]    = in0_bad;       // RL1
      next_status[plst_pkg::ST_IN1]    = in1_bad;       // RL2
      next_status[plst_pkg::ST_XTAL]   = xtal_bad;      // RL3
      next_status[plst_pkg::ST_LOCK]   = locked;        // RL4
      next_status[plst_pkg::ST_FREEZE] = detector_bad;  // RL5
      next_status[plst_pkg::ST_ACTIVE] = active_input;  // RL6
   end

   // tuning field holds until written
   always_comb begin
      next_tune = wr_en ? wr_data : loop_tuning_bits;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         status_word       <= '0;
         loop_tuning_bits  <= plst_pkg::TUNE_RESET;
      end else begin
         status_word       <= next_status;  // RL17
         loop_tuning_bits  <= next_tune;
      end
   end

   // pins are registered from next_status beside the status bits, one cycle behind the conditions
   always_ff @(posedge clk) begin
      if (!rstn) begin
         input0_fail_flag  <= 1'b0;
         input1_fail_flag  <= 1'b0;
         crystal_fail_flag <= 1'b0;
         pll_lock_flag     <= 1'b0;
         freeze_state_flag <= 1'b0;
         active_input_flag <= 1'b0;
         oscillator_hold   <= 1'b0;
      end else begin
         input0_fail_flag  <= next_status[plst_pkg::ST_IN0];     // RL1
         input1_fail_flag  <= next_status[plst_pkg::ST_IN1];     // RL2
         crystal_fail_flag <= next_status[plst_pkg::ST_XTAL];    // RL3
         pll_lock_flag     <= next_status[plst_pkg::ST_LOCK];    // RL4
         freeze_state_flag <= next_status[plst_pkg::ST_FREEZE];  // RL5
         active_input_flag <= next_status[plst_pkg::ST_ACTIVE];  // RL6
         oscillator_hold   <= next_status[plst_pkg::ST_FREEZE];  // RL5
      end
   end

   // ==========================================================
   // tuning decode
   logic       low_bw;
   logic [1:0] n_lf;
   logic       n_ord;
   logic       n_en;
   logic [1:0] n_ucp;
   logic       n_red;
   logic [3:0] n_gain;
   logic [1:0] n_lcp;
   logic [9:0] n_uua;
   logic [9:0] n_lua;

   // decode from next_tune so the decoded view never lags the field
   always_comb begin
      low_bw = (mode_sel == plst_pkg::PLST_MODE_LOW_BW);  // RL16
      n_red  = next_tune[plst_pkg::REDUCE_BIT];
      n_gain = '0;
      n_lcp  = '0;
      n_ord  = 1'b0;
      n_en   = 1'b0;
      if (low_bw) begin
         n_lf   = plst_pkg::FORCED_CODE;                          // RL9
         n_ucp  = plst_pkg::FORCED_CODE;                          // RL12
         n_gain = next_tune[plst_pkg::GAIN_HI:plst_pkg::GAIN_LO]; // RL8
         n_lcp  = next_tune[plst_pkg::CP_HI:plst_pkg::CP_LO];     // RL8
      end else begin
         n_lf   = next_tune[plst_pkg::LF_HI:plst_pkg::LF_LO];     // RL7
         n_ord  = next_tune[plst_pkg::ORD_BIT];                   // RL7
         n_en   = next_tune[plst_pkg::MODULATOR_ENABLE_BIT_BIT];                // RL7
         n_ucp  = next_tune[plst_pkg::CP_HI:plst_pkg::CP_LO];     // RL7
      end
      // base currents; reserved code shows zero
      unique case (n_ucp)
         2'h0:    n_uua = plst_pkg::UPPER_UA_0;  // RL12
         2'h1:    n_uua = plst_pkg::UPPER_UA_1;
         2'h2:    n_uua = plst_pkg::UPPER_UA_2;
         default: n_uua = '0;
      endcase
      // two thirds, integer result truncates
      if (n_red) begin
         n_uua = 10'((n_uua * 11'h002) / 11'h003);  // RL13
      end
      unique case (n_lcp)
         2'h0:    n_lua = plst_pkg::LOWER_UA_0;  // RL14
         2'h1:    n_lua = plst_pkg::LOWER_UA_1;
         2'h2:    n_lua = plst_pkg::LOWER_UA_2;
         default: n_lua = plst_pkg::LOWER_UA_3;
      endcase
      if (!low_bw) begin
         n_lua = '0;  // RL14
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         upper_loop_filter_sel  <= '0;
         modulator_order_bit    <= 1'b0;
         modulator_enable_bit   <= 1'b0;
         upper_pump_current_sel <= '0;
         upper_pump_reduce_bit  <= 1'b0;
         converter_gain         <= '0;
         lower_pump_current_sel <= '0;
         upper_pump_ua          <= '0;
         lower_pump_ua          <= '0;
         third_order            <= 1'b0;
         fractional_feedback    <= 1'b0;
         lower_loop_on          <= 1'b0;
         upper_cp_reserved      <= 1'b0;
      end else begin
         upper_loop_filter_sel  <= n_lf;
         modulator_order_bit    <= n_ord;
         modulator_enable_bit   <= n_en;
         upper_pump_current_sel <= n_ucp;
         upper_pump_reduce_bit  <= n_red;
         converter_gain         <= n_gain;
         lower_pump_current_sel <= n_lcp;
         upper_pump_ua          <= n_uua;
         lower_pump_ua          <= n_lua;
         third_order            <= n_ord;   // RL10
         fractional_feedback    <= n_en;    // RL11
         lower_loop_on          <= low_bw;  // RL14
         upper_cp_reserved      <= (n_ucp == plst_pkg::CP_RESERVED);
      end
   end

   // ==========================================================
   // checks
   // pin and status bit are both held against the condition, not against each other
   a_in0_mirror: assert property (@(posedge clk) disable iff (!rstn)  // RL1
      ##1 input0_fail_flag == $past(in0_bad) && status_word[plst_pkg::ST_IN0] == $past(in0_bad))
      else $error("input0 pin or status differs from condition");
   a_in1_follow: assert property (@(posedge clk) disable iff (!rstn)  // RL2
      in1_bad |=> input1_fail_flag) else $error("input1 flag not set");
   a_xtal_clear: assert property (@(posedge clk) disable iff (!rstn)  // RL3
      !xtal_bad |=> !crystal_fail_flag) else $error("crystal flag not cleared");
   a_lock_track: assert property (@(posedge clk) disable iff (!rstn)  // RL4
      $rose(locked) |=> pll_lock_flag) else $error("lock flag late");
   a_freeze_hold: assert property (@(posedge clk) disable iff (!rstn)  // RL5
      detector_bad |=> freeze_state_flag && oscillator_hold) else $error("freeze not held");
   a_active_follow: assert property (@(posedge clk) disable iff (!rstn)  // RL6
      ##1 active_input_flag == $past(active_input)) else $error("active input wrong");
   a_low_force: assert property (@(posedge clk) disable iff (!rstn)  // RL9
      mode_sel == 2'h0 |=> upper_loop_filter_sel == 2'h0 && upper_pump_current_sel == 2'h0)
      else $error("low-bw upper codes not forced");
   a_synth_map: assert property (@(posedge clk) disable iff (!rstn)  // RL7
      mode_sel == 2'h1 |=> upper_loop_filter_sel == loop_tuning_bits[6:5]
         && modulator_order_bit == loop_tuning_bits[4]) else $error("synth decode wrong");
   a_low_gain: assert property (@(posedge clk) disable iff (!rstn)  // RL8
      mode_sel == 2'h0 |=> converter_gain == loop_tuning_bits[6:3]) else $error("gain decode wrong");
   a_lower_ua: assert property (@(posedge clk) disable iff (!rstn)  // RL14
      mode_sel == 2'h0 && wr_en && wr_data[2:1] == 2'h3 |=> lower_pump_ua == 10'h064)
      else $error("lower pump current wrong");
   a_reduce_ua: assert property (@(posedge clk) disable iff (!rstn)  // RL13
      mode_sel == 2'h0 && wr_en && wr_data[0] |=> upper_pump_ua == 10'h073)
      else $error("reduced current wrong");
endmodule

// *** tb_top.sv ***
// Purpose: self-checking bench for the pll status and loop tuning block
// Assumes: inputs driven on the falling edge, outputs registered one edge later
// Notes:   every write goes out back to back, so the second value must win
`timescale 1ns/1ps
module tb_top;
   logic        clk;
   logic        rstn;
   logic        wr_en;
   logic [1:0]  mode_sel;
   logic [6:0]  wr_data;
   logic [5:0]  cond;
   logic [6:0]  loop_tuning_bits;
   logic [5:0]  status_word;
   logic        input0_fail_flag, input1_fail_flag, crystal_fail_flag, pll_lock_flag;
   logic        freeze_state_flag, active_input_flag, oscillator_hold;
   logic [1:0]  upper_loop_filter_sel, upper_pump_current_sel, lower_pump_current_sel;
   logic        modulator_order_bit, modulator_enable_bit, upper_pump_reduce_bit;
   logic [3:0]  converter_gain;
   logic [9:0]  upper_pump_ua, lower_pump_ua;
   logic        third_order, fractional_feedback, lower_loop_on, upper_cp_reserved;
   logic [6:0]  d;
   logic [2:0]  kk;
   int          err_count, check_count, cyc;

   plst_top dut_u (.clk, .rstn, .mode_sel, .wr_en, .wr_data, .in0_bad(cond[0]), .in1_bad(cond[1]),
      .xtal_bad(cond[2]), .locked(cond[3]), .detector_bad(cond[4]), .active_input(cond[5]),
      .loop_tuning_bits, .status_word, .input0_fail_flag, .input1_fail_flag, .crystal_fail_flag,
      .pll_lock_flag, .freeze_state_flag, .active_input_flag, .oscillator_hold, .upper_loop_filter_sel,
      .modulator_order_bit, .modulator_enable_bit, .upper_pump_current_sel, .upper_pump_reduce_bit,
      .converter_gain, .lower_pump_current_sel, .upper_pump_ua, .lower_pump_ua, .third_order,
      .fractional_feedback, .lower_loop_on, .upper_cp_reserved);

   // ==========================================================
   // clock, hang guard and verdict
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // the whole run needs a few hundred cycles, so 2000 means a hang
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      if (err_count == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // access tasks and expectations
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // two writes on consecutive edges; a refused or dropped second write shows as the inverse
   task automatic wr(input logic [6:0] v);
      wr_en = 1'b1;
      wr_data = ~v;
      @(negedge clk);
      wr_data = v;
      @(negedge clk);
      wr_en = 1'b0;
      repeat (3) @(negedge clk);
   endtask

   // reduced current keeps two thirds of the base, truncated
   function automatic logic [9:0] up_ua(input logic [1:0] cp, input logic red);
      int b;
      b = (cp == 2'h0) ? 173 : (cp == 2'h1) ? 346 : (cp == 2'h2) ? 692 : 0;
      if (red) b = b * 2 / 3;
      return 10'(b);
   endfunction

   // ==========================================================
   // main sequence
   initial begin
      rstn = 1'b0;
      wr_en = 1'b0;
      wr_data = 7'h00;
      mode_sel = 2'h1;
      cond = 6'h00;
      repeat (12) @(negedge clk);
      chk("reset", {3'h0, status_word, loop_tuning_bits}, 16'h0000);
      rstn = 1'b1;
      // one condition at a time, then all with a write aimed at them
      for (int i = 0; i < 6; i++) begin
         cond = 6'(1 << i);
         repeat (3) @(negedge clk);
         chk("status", {4'h0, status_word, active_input_flag, freeze_state_flag, pll_lock_flag,
            crystal_fail_flag, input1_fail_flag, input0_fail_flag}, {4'h0, cond, cond});
         chk("hold", 16'(oscillator_hold), 16'(i == 4));
      end
      cond = 6'h3f;
      wr(7'h00);
      chk("status_ro", 16'(status_word), 16'h003f);
      cond = 6'h00;
      repeat (3) @(negedge clk);
      chk("self_clear", 16'(status_word), 16'h0000);
      // synthesizer and both high-bandwidth codes
      for (int m = 1; m < 4; m++) begin
         mode_sel = 2'(m);
         for (int k = 0; k < 8; k++) begin
            kk = 3'(k);
            d = {2'(k + m), kk[1], ~kk[0], kk[2:1], kk[0]};
            wr(d);
            chk("field", 16'(loop_tuning_bits), 16'(d));
            chk("filter", 16'(upper_loop_filter_sel), 16'(d[6:5]));
            chk("order", 16'({modulator_order_bit, third_order}), 16'({2{d[4]}}));
            chk("enable", 16'({modulator_enable_bit, fractional_feedback}), 16'({2{d[3]}}));
            chk("upper_cp", 16'({upper_pump_current_sel, upper_pump_reduce_bit, upper_cp_reserved}),
               16'({d[2:0], d[2:1] == 2'h3}));
            chk("upper_ua", 16'(upper_pump_ua), 16'(up_ua(d[2:1], d[0])));
            chk("lower_off", 16'({lower_loop_on, lower_pump_current_sel, converter_gain}), 16'h0000);
            chk("lower_ua_off", 16'(lower_pump_ua), 16'h0000);
         end
      end
      // advised setting for the widest high-bandwidth loop
      mode_sel = 2'h2;
      wr(7'h64);
      chk("widest", 16'({upper_loop_filter_sel, upper_pump_reduce_bit, upper_pump_ua}),
         16'({2'h3, 1'b0, 10'h02b4}));
      // low-bandwidth: upper fields forced, lower loop decoded
      mode_sel = 2'h0;
      for (int k = 0; k < 8; k++) begin
         kk = 3'(k);
         d = {4'(k * 5 + 3), kk[2:1], kk[0]};
         wr(d);
         chk("gain", 16'(converter_gain), 16'(d[6:3]));
         chk("forced", 16'({upper_loop_filter_sel, upper_pump_current_sel, modulator_order_bit,
            modulator_enable_bit}), 16'h0000);
         chk("low_upper", 16'({upper_pump_reduce_bit, upper_pump_ua}), 16'({d[0], up_ua(2'h0, d[0])}));
         chk("lower_ua", 16'({lower_loop_on, lower_pump_current_sel, lower_pump_ua}),
            16'({1'b1, d[2:1], 10'(800 >> d[2:1])}));
      end
      give_verdict();
   end
endmodule
